// >>> rtl/rwf_pkg.sv
// package for the receive word frame identifier
package rwf_pkg;
  localparam int DATA_W = 32;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
  localparam logic [CNT_W-1:0] BCAST_GOOD_COUNT = 8'h02;
  localparam logic [6:0] SEQ_STEP = 7'h01;
  localparam int BUF_DEPTH = 2;
  typedef enum logic [3:0] {
    RWF_CW_NONE,
    RWF_CW_START_DATA,
    RWF_CW_END_DATA,
    RWF_CW_START_BCAST,
    RWF_CW_END_BCAST,
    RWF_CW_START_IDLE,
    RWF_CW_RETRY,
    RWF_CW_FLOW_CREDIT,
    RWF_CW_ACK,
    RWF_CW_NACK,
    RWF_CW_BUF_FULL
  } rwf_cw_e;
  typedef enum logic [1:0] {
    RWF_KIND_NONE,
    RWF_KIND_DATA,
    RWF_KIND_BCAST,
    RWF_KIND_IDLE
  } rwf_kind_e;
  typedef enum logic [2:0] {
    NO_FRAME_STATE,
    DATA_FRAME_STATE,
    BCAST_FRAME_STATE,
    BCAST_WITHIN_DATA_STATE,
    IDLE_FRAME_STATE
  } rwf_state_e;
endpackage : rwf_pkg

// >>> rtl/rwf_identifier.sv
// receive data word frame identifier with two-entry output buffer
//
// What this block does
// - start data word enters data frame
// - data frame state labels words data
// - retry, rx error, crc, sequence exits first
// - start broadcast nests inside data frame
// - end data returns to no frame
// - stray delimiters in data frame abort
// - start broadcast enters broadcast frame
// - broadcast states label and count words
// - end broadcast returns to no frame
// - stray delimiters in broadcast abort
// - nested end with count two resumes data
// - nested end other count aborts
// - start idle enters idle; labels idle
// - idle exits on retry, rx error only
// - end delimiters in idle abort
// - idle moves on start data and start broadcast words
// - link control words accepted everywhere
// - no frame exits by priority order
// - resets and flush force no frame
// - sequence error from frame numbers
`timescale 1ns/1ps
module rwf_identifier
  import rwf_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic warm_reset,
  input wire logic remote_flush,
  input wire logic ctrl_valid,
  input wire rwf_cw_e ctrl_word,
  input wire logic [6:0] ctrl_seq_num,
  input wire logic [6:0] rx_seq_count,
  input wire logic rx_error_indication,
  input wire logic crc_error,
  input wire logic in_valid,
  input wire logic [DATA_W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [DATA_W-1:0] out_data,
  output rwf_kind_e out_kind,
  input wire logic out_ready,
  output rwf_state_e frame_state,
  output logic [CNT_W-1:0] bcast_count,
  output logic seq_error,
  output logic link_ctrl_valid,
  output rwf_cw_e link_ctrl_word
);

  ////////////////////////////////////////////////////////////////////////////
  // control word decode
  wire cw_sdf = ctrl_valid && (ctrl_word == RWF_CW_START_DATA);
  wire cw_edf = ctrl_valid && (ctrl_word == RWF_CW_END_DATA);
  wire cw_sbf = ctrl_valid && (ctrl_word == RWF_CW_START_BCAST);
  wire cw_ebf = ctrl_valid && (ctrl_word == RWF_CW_END_BCAST);
  wire cw_sif = ctrl_valid && (ctrl_word == RWF_CW_START_IDLE);
  wire cw_retry = ctrl_valid && (ctrl_word == RWF_CW_RETRY);
  wire cw_link = ctrl_valid && (ctrl_word == RWF_CW_FLOW_CREDIT || ctrl_word == RWF_CW_ACK
    || ctrl_word == RWF_CW_NACK || ctrl_word == RWF_CW_BUF_FULL || cw_retry);
  wire [6:0] seq_plus_one = 7'(rx_seq_count + SEQ_STEP);
  wire seq_numbered = cw_sdf || cw_edf || cw_sbf || cw_ebf
    || (ctrl_valid && ctrl_word == RWF_CW_FLOW_CREDIT);
  wire seq_bad = (seq_numbered && ctrl_seq_num != seq_plus_one)
    || (cw_sif && ctrl_seq_num != rx_seq_count);
  wire flush = reset || warm_reset || remote_flush;
  // exits on link faults, priority order
  wire fault_exit = cw_retry || rx_error_indication || crc_error || seq_bad;
  // idle sees only retry and rx error
  wire idle_fault = cw_retry || rx_error_indication;
  wire in_bcast = frame_state == BCAST_FRAME_STATE || frame_state == BCAST_WITHIN_DATA_STATE;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  rwf_state_e next_state;
  always_comb begin
    next_state = frame_state;
    unique case (frame_state)
      NO_FRAME_STATE: begin
        if (cw_sbf) begin
          next_state = BCAST_FRAME_STATE;
        end else if (cw_sdf) begin
          next_state = DATA_FRAME_STATE;
        end else if (cw_sif) begin
          next_state = IDLE_FRAME_STATE;
        end
      end
      DATA_FRAME_STATE: begin
        if (fault_exit) begin
          next_state = NO_FRAME_STATE;
        end else if (cw_sbf) begin
          next_state = BCAST_WITHIN_DATA_STATE;
        end else if (cw_edf) begin
          next_state = NO_FRAME_STATE;
        end else if (cw_sdf || cw_sif || cw_ebf) begin
          next_state = NO_FRAME_STATE;
        end
      end
      BCAST_FRAME_STATE: begin
        if (fault_exit) begin
          next_state = NO_FRAME_STATE;
        end else if (cw_ebf) begin
          next_state = NO_FRAME_STATE;
        end else if (cw_sdf || cw_sbf || cw_sif || cw_edf) begin
          next_state = NO_FRAME_STATE;
        end
      end
      BCAST_WITHIN_DATA_STATE: begin
        if (fault_exit) begin
          next_state = NO_FRAME_STATE;
        end else if (cw_ebf) begin
          // resume data only on count two
          next_state = (bcast_count == BCAST_GOOD_COUNT) ? DATA_FRAME_STATE : NO_FRAME_STATE;
        end else if (cw_sdf || cw_sbf || cw_sif || cw_edf) begin
          next_state = NO_FRAME_STATE;
        end
      end
      IDLE_FRAME_STATE: begin
        if (idle_fault) begin
          next_state = NO_FRAME_STATE;
        end else if (cw_edf || cw_ebf) begin
          next_state = NO_FRAME_STATE;
        end else if (cw_sbf) begin
          next_state = BCAST_FRAME_STATE;
        end else if (cw_sdf) begin
          next_state = DATA_FRAME_STATE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // word labelling and output buffer
  rwf_kind_e cur_kind;
  always_comb begin
    unique case (frame_state)
      DATA_FRAME_STATE: cur_kind = RWF_KIND_DATA;
      BCAST_FRAME_STATE, BCAST_WITHIN_DATA_STATE: cur_kind = RWF_KIND_BCAST;
      IDLE_FRAME_STATE: cur_kind = RWF_KIND_IDLE;
      default: cur_kind = RWF_KIND_NONE;
    endcase
  end

  logic [DATA_W-1:0] buf_data [BUF_DEPTH];
  rwf_kind_e buf_kind [BUF_DEPTH];
  logic [1:0] buf_fill;
  logic wr_ptr;
  logic rd_ptr;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [1:0] next_fill = 2'(buf_fill + {1'b0, push} - {1'b0, pop});
  wire [1:0] fill_after_pop = 2'(buf_fill - {1'b0, pop});
  wire rd_next = rd_ptr ^ pop;

  always_ff @(posedge clk) begin
    if (push) begin
      buf_data[wr_ptr] <= in_data;
      buf_kind[wr_ptr] <= cur_kind;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      buf_fill <= 2'h0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      buf_fill <= next_fill;
      wr_ptr <= wr_ptr ^ push;
      rd_ptr <= rd_next;
      in_ready <= next_fill != 2'(BUF_DEPTH);
      out_valid <= next_fill != 2'h0;
    end
  end

  // registered head of buffer, with bypass for an empty buffer
  always_ff @(posedge clk) begin
    if (reset) begin
      out_data <= '0;
      out_kind <= RWF_KIND_NONE;
    end else if (fill_after_pop == 2'h0) begin
      out_data <= in_data;
      out_kind <= cur_kind;
    end else begin
      out_data <= buf_data[rd_next];
      out_kind <= buf_kind[rd_next];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state, counter and status registers
  wire bcast_entry = (next_state == BCAST_FRAME_STATE || next_state == BCAST_WITHIN_DATA_STATE)
    && !in_bcast;

  always_ff @(posedge clk) begin
    if (flush) begin
      frame_state <= NO_FRAME_STATE;
    end else begin
      frame_state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (flush) begin
      bcast_count <= CNT_RESET;
    end else if (bcast_entry) begin
      bcast_count <= CNT_RESET;
    end else if (in_bcast && push) begin
      bcast_count <= CNT_W'(bcast_count + 8'h01);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      seq_error <= 1'b0;
      link_ctrl_valid <= 1'b0;
      link_ctrl_word <= RWF_CW_NONE;
    end else begin
      seq_error <= seq_bad;
      // pass link control in any state
      link_ctrl_valid <= cw_link;
      link_ctrl_word <= cw_link ? ctrl_word : RWF_CW_NONE;
    end
  end

endmodule : rwf_identifier

// >>> tb/rwf_sink_model.sv
// sink model that stalls the output stream
`timescale 1ns/1ps
module rwf_sink_model (
  input wire logic clk,
  input wire logic hold,
  output logic out_ready
);
  initial out_ready = 1'h0;
  always @(negedge clk) begin
    out_ready <= !hold && $urandom % 3 != 0;
  end
endmodule : rwf_sink_model

// >>> tb/rwf_identifier_asserts.sv
// port checker for the frame identifier
`timescale 1ns/1ps
module rwf_identifier_asserts
  import rwf_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic warm_reset,
  input wire logic remote_flush,
  input wire logic ctrl_valid,
  input wire rwf_cw_e ctrl_word,
  input wire logic [6:0] ctrl_seq_num,
  input wire logic [6:0] rx_seq_count,
  input wire logic rx_error_indication,
  input wire logic crc_error,
  input wire rwf_state_e frame_state,
  input wire logic [CNT_W-1:0] bcast_count,
  input wire logic link_ctrl_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire ok = !warm_reset && !remote_flush;
  wire go = ctrl_valid && ok && !rx_error_indication && !crc_error
    && ctrl_seq_num == rx_seq_count + SEQ_STEP;
  wire nf = frame_state inside {NO_FRAME_STATE, IDLE_FRAME_STATE};
  wire sb = go && ctrl_word == RWF_CW_START_BCAST;
  wire eb = go && frame_state == BCAST_WITHIN_DATA_STATE && ctrl_word == RWF_CW_END_BCAST;
  flush_none_a: assert property (
    warm_reset || remote_flush |=> frame_state == NO_FRAME_STATE && bcast_count == CNT_RESET)
    else $error("flush kept frame");
  data_start_a: assert property (
    nf && go && ctrl_word == RWF_CW_START_DATA |=> frame_state == DATA_FRAME_STATE)
    else $error("data start lost");
  bcast_start_a: assert property (
    nf && sb |=> frame_state == BCAST_FRAME_STATE && bcast_count == CNT_RESET)
    else $error("bcast start lost");
  nest_enter_a: assert property (
    frame_state == DATA_FRAME_STATE && sb |=> frame_state == BCAST_WITHIN_DATA_STATE)
    else $error("nest not entered");
  fault_exit_a: assert property (
    frame_state inside {[DATA_FRAME_STATE:BCAST_WITHIN_DATA_STATE]} && ok && (crc_error
    || rx_error_indication || ctrl_valid && ctrl_word == RWF_CW_RETRY)
    |=> frame_state == NO_FRAME_STATE) else $error("fault kept frame");
  nest_resume_a: assert property (
    eb && bcast_count == BCAST_GOOD_COUNT |=> frame_state == DATA_FRAME_STATE)
    else $error("data not resumed");
  nest_abort_a: assert property (
    eb && bcast_count != BCAST_GOOD_COUNT |=> frame_state == NO_FRAME_STATE)
    else $error("bad length kept");
  link_pass_a: assert property (
    ctrl_valid && ctrl_word inside {[RWF_CW_RETRY:RWF_CW_BUF_FULL]} |=> link_ctrl_valid)
    else $error("link word lost");
  cover property (frame_state == BCAST_WITHIN_DATA_STATE ##1 frame_state == DATA_FRAME_STATE);
  cover property (frame_state == IDLE_FRAME_STATE ##1 frame_state == BCAST_FRAME_STATE);
  cover property (frame_state == DATA_FRAME_STATE && crc_error);
endmodule : rwf_identifier_asserts
bind rwf_identifier rwf_identifier_asserts chk (.*);

// >>> tb/rwf_identifier_tb_top.sv
// self-checking bench for the frame identifier
`timescale 1ns/1ps
module rwf_identifier_tb_top;
  import rwf_pkg::*;
  logic clk, reset, warm_reset, remote_flush, ctrl_valid, rx_error_indication, crc_error;
  logic in_valid, in_ready, out_valid, out_ready, seq_error, link_ctrl_valid, hold;
  logic [6:0] ctrl_seq_num, rx_seq_count;
  logic [DATA_W-1:0] in_data, out_data;
  logic [CNT_W-1:0] bcast_count, cnt;
  rwf_cw_e ctrl_word, link_ctrl_word;
  rwf_kind_e out_kind;
  rwf_state_e frame_state, st;
  rwf_kind_e kt[5] = '{RWF_KIND_NONE, RWF_KIND_DATA, RWF_KIND_BCAST, RWF_KIND_BCAST, RWF_KIND_IDLE};
  logic [DATA_W+1:0] q[$];
  int num_errors, cmp_count;
  rwf_identifier dut (.*);
  rwf_sink_model sink (.clk(clk), .hold(hold), .out_ready(out_ready));
  task automatic stop_test();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  task automatic cmp(string n, logic [DATA_W+1:0] e, logic [DATA_W+1:0] a);
    cmp_count++;
    if (a !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, a);
    end
  endtask : cmp
  function automatic rwf_state_e nxt(rwf_state_e s, rwf_cw_e c, logic re, logic ce);
    logic d;
    d = c inside {[RWF_CW_START_DATA:RWF_CW_START_IDLE]};
    if (s != NO_FRAME_STATE && (re || c == RWF_CW_RETRY)) return NO_FRAME_STATE;
    if (s inside {[DATA_FRAME_STATE:BCAST_WITHIN_DATA_STATE]} && ce) return NO_FRAME_STATE;
    if (s == DATA_FRAME_STATE && c == RWF_CW_START_BCAST) return BCAST_WITHIN_DATA_STATE;
    if (s == BCAST_WITHIN_DATA_STATE && c == RWF_CW_END_BCAST && cnt == BCAST_GOOD_COUNT)
      return DATA_FRAME_STATE;
    if (s == NO_FRAME_STATE || s == IDLE_FRAME_STATE) begin
      if (c == RWF_CW_START_BCAST) return BCAST_FRAME_STATE;
      if (c == RWF_CW_START_DATA) return DATA_FRAME_STATE;
      if (c == RWF_CW_START_IDLE) return IDLE_FRAME_STATE;
    end
    return d ? NO_FRAME_STATE : s;
  endfunction : nxt
  task automatic ctl(rwf_cw_e c, logic re = 1'h0, logic ce = 1'h0, logic bad = 1'h0);
    logic sq;
    rwf_state_e o;
    sq = bad && c inside {[RWF_CW_START_DATA:RWF_CW_START_IDLE], RWF_CW_FLOW_CREDIT};
    rx_seq_count = 7'($urandom);
    ctrl_seq_num = rx_seq_count + 7'(c != RWF_CW_START_IDLE) + 7'(bad);
    ctrl_word = c;
    {ctrl_valid, rx_error_indication, crc_error} = {1'h1, re, ce};
    @(negedge clk);
    {ctrl_valid, rx_error_indication, crc_error} = 3'h0;
    o = st;
    st = nxt(o, c, re, ce || sq);
    cmp("frame_state", st, frame_state);
    cmp("seq_error", sq, seq_error);
    cmp("link_ctrl_valid", c inside {[RWF_CW_RETRY:RWF_CW_BUF_FULL]}, link_ctrl_valid);
    cmp("link_ctrl_word", c inside {[RWF_CW_RETRY:RWF_CW_BUF_FULL]} ? c : RWF_CW_NONE,
      link_ctrl_word);
    if (st != o && st inside {BCAST_FRAME_STATE, BCAST_WITHIN_DATA_STATE}) begin
      cnt = CNT_RESET;
      cmp("bcast_count", cnt, bcast_count);
    end
    @(negedge clk);
  endtask : ctl
  task automatic dat(logic [DATA_W-1:0] d);
    q.push_back({kt[st], d});
    {in_valid, in_data} = {1'h1, d};
    @(posedge clk);
    while (!in_ready) @(posedge clk);
    @(negedge clk);
    in_valid = 1'h0;
    if (st inside {BCAST_FRAME_STATE, BCAST_WITHIN_DATA_STATE}) begin
      cnt++;
      cmp("bcast_count", cnt, bcast_count);
    end
    @(negedge clk);
  endtask : dat
  task automatic flush(logic w);
    {warm_reset, remote_flush} = {w, !w};
    @(negedge clk);
    {warm_reset, remote_flush} = 2'h0;
    st = NO_FRAME_STATE;
    cnt = CNT_RESET;
    cmp("frame_state", st, frame_state);
    cmp("bcast_count", cnt, bcast_count);
    @(negedge clk);
  endtask : flush
  always @(posedge clk) begin
    if (!reset && out_valid && out_ready) begin
      cmp("out_word", q.pop_front(), {out_kind, out_data});
    end
  end
  ////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25 * 20000);
    num_errors++;
    stop_test();
  end
  initial begin
    {reset, warm_reset, remote_flush, ctrl_valid, rx_error_indication, crc_error} = 6'h20;
    {in_valid, hold, ctrl_seq_num, rx_seq_count} = 16'h0;
    in_data = 32'h0;
    ctrl_word = RWF_CW_NONE;
    st = NO_FRAME_STATE;
    cnt = CNT_RESET;
    void'($urandom(32'h126502A7));
    repeat (5) @(negedge clk);
    reset = 1'h0;
    cmp("in_ready", 1'h1, in_ready);
    for (int n = 0; n < 4; n++) begin
      ctl(RWF_CW_START_DATA);
      ctl(RWF_CW_START_BCAST);
      repeat (n) dat($urandom);
      ctl(RWF_CW_END_BCAST);
      ctl(RWF_CW_END_DATA);
    end
    for (int k = 0; k < 44; k++) begin
      ctl(k % 4 == 1 ? RWF_CW_START_BCAST : k % 4 == 3 ? RWF_CW_START_IDLE : RWF_CW_START_DATA);
      if (k % 4 == 2) ctl(RWF_CW_START_BCAST);
      dat($urandom);
      ctl(rwf_cw_e'(k / 4));
      ctl(RWF_CW_RETRY);
    end
    while (q.size() != 0) @(negedge clk);
    hold = 1'h1;
    @(negedge clk);
    repeat (2) dat($urandom);
    repeat (3) @(negedge clk);
    cmp("in_ready", 1'h0, in_ready);
    hold = 1'h0;
    repeat (800) begin
      case ($urandom % 16)
        0: flush($urandom % 2 == 0);
        1, 2, 3, 4, 5: dat($urandom);
        default: ctl(rwf_cw_e'($urandom % 11), $urandom % 12 == 0, $urandom % 12 == 0,
          $urandom % 12 == 0);
      endcase
    end
    while (q.size() != 0) @(negedge clk);
    stop_test();
  end
endmodule : rwf_identifier_tb_top
